// ---- rtl/aclr_indirect_access.sv ----
// Indirect host access path and per-port staging for the rule tables
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R1] Host should read, modify and write back whole 128-bit entries, 112 bits used.
// [R2] Entry read needs two control writes, two control reads, then data reads.
// [R3] Entry write needs one control read and three control writes.
// [R4] Select register low four bits give the port, indirect address bits 11..8.
// [R5] Offset register gives the byte offset, indirect address bits 7..0.
// [R6] Offsets 0x00..0x0D map to entry bytes 15 downward.
// [R7] Offsets 0x0E and 0x0F are reserved entry bytes.
// [R8] Offsets 0x10 and 0x11 hold a per-byte enable mask.
// [R9] Rule_transfer_control_status is the transfer control and status byte.
// [R10] Rule_first_index_byte bits 3..0 hold the first rule index, reset zero.
// [R11] Every port has its own sixteen-entry rule table.
// [R12] Entry bytes at 0x0C and 0x0D combine rules into a set.
// [R13] First rule index picks which entry's action applies on a match.
// [R14] Rule_mode_byte bits 5..4 select rule mode; bits 7..6 reserved.
// [R15] Data register carries the byte chosen by port and offset.
// [R16] Host uses port values 1 to 5.
// [R17] Select bits 7..5 equal 010 target the rule tables.
// [R18] Select bit 4 set means read, clear means write.
// [R19] Writing the offset register triggers the selected operation; here only a read, a staging write lands on the data register write.
// [R20] Reserved offsets and bits ignore writes and read as zero.
module aclr_indirect_access #(
   parameter int NUM_PORTS = aclr_pkg::NUM_PORTS,
   parameter int NUM_ENTRIES = aclr_pkg::NUM_ENTRIES,
   parameter int PORT_W = $clog2(NUM_PORTS),
   parameter int ENTRY_W = $clog2(NUM_ENTRIES)
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   // Host byte register port
   input wire logic i_reg_wr_en,
   input wire logic i_reg_rd_en,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rd_valid,
   // Rule lookup for the matching engine
   input wire logic [PORT_W-1:0] i_lookup_port,
   input wire logic [ENTRY_W-1:0] i_lookup_entry,
   output logic [aclr_pkg::ENTRY_BITS-1:0] o_lookup_word,
   output logic [aclr_pkg::FIRST_W-1:0] o_lookup_first_index,
   output logic [aclr_pkg::MODE_W-1:0] o_lookup_mode,
   output logic o_lookup_active
);
   localparam int BB = aclr_pkg::BYTE_BITS;

   // Direct registers
   logic [7:0] sel_ff;
   logic [7:0] off_ff;
   logic [7:0] data_ff;

   // Per-port staging entry, byte enables and transfer control
   logic [aclr_pkg::ENTRY_BITS-1:0] stage_ff [NUM_PORTS];
   logic [aclr_pkg::BE_BITS-1:0] be_ff [NUM_PORTS];
   logic [aclr_pkg::CTRL_W-1:0] ctrl_ff [NUM_PORTS];

   // Transfer engine
   aclr_pkg::aclr_state_t state_ff;
   aclr_pkg::aclr_state_t nxt_state;
   logic [PORT_W-1:0] eng_port_ff;
   logic [ENTRY_W-1:0] eng_entry_ff;
   logic eng_dir_wr_ff;
   logic done_ff;

   // Decoded select and host strobes
   logic sel_is_rules;
   logic sel_is_read;
   logic [aclr_pkg::SEL_PORT_W-1:0] port_num;
   logic port_ok;
   logic [PORT_W-1:0] port_idx;
   logic wr_sel;
   logic wr_off;
   logic wr_data;
   logic data_hit;
   logic start_req;
   logic busy;
   logic [7:0] rd_loc;

   aclr_tbl_if #(
      .PORT_W(PORT_W),
      .ENTRY_W(ENTRY_W),
      .DATA_W(aclr_pkg::ENTRY_BITS),
      .MASK_W(aclr_pkg::ENTRY_BYTES)
   ) tbl ();

   // Bit position of the entry byte named by an offset
   function automatic logic [6:0] byte_lsb(input logic [7:0] off);
      return 7'(BB * (int'(aclr_pkg::OFF_LAST_CONTENT) - int'(off))); // [R6]
   endfunction : byte_lsb

   // Writable bits of entry and enable bytes; reserved space and the control byte give zero
   function automatic logic [7:0] loc_mask(input logic [7:0] off);
      if (off == aclr_pkg::OFF_FIRST) begin
         return aclr_pkg::MASK_FIRST; // [R10]
      end else if (off == aclr_pkg::OFF_MODE) begin
         return aclr_pkg::MASK_MODE; // [R14]
      end else if (off <= aclr_pkg::OFF_LAST_CONTENT) begin
         return aclr_pkg::MASK_FULL;
      end else if (off == aclr_pkg::OFF_BE_HI || off == aclr_pkg::OFF_BE_LO) begin
         return aclr_pkg::MASK_FULL; // [R8]
      end else begin
         return aclr_pkg::MASK_NONE; // [R7] [R20]
      end
   endfunction : loc_mask

   // Widen the content byte enables into a bit mask
   function automatic logic [aclr_pkg::ENTRY_BITS-1:0] bit_mask(
      input logic [aclr_pkg::ENTRY_BYTES-1:0] be);
      logic [aclr_pkg::ENTRY_BITS-1:0] m;
      m = '0;
      for (int b = 0; b < aclr_pkg::ENTRY_BYTES; b++) begin
         m[b*BB +: BB] = {BB{be[b]}};
      end
      return m;
   endfunction : bit_mask

   // Select register decode
   assign sel_is_rules = sel_ff[aclr_pkg::SEL_TGT_LSB +: aclr_pkg::SEL_TGT_W]
                         == aclr_pkg::TARGET_RULES; // [R17]
   assign sel_is_read = sel_ff[aclr_pkg::SEL_DIR_BIT]; // [R18]
   assign port_num = sel_ff[aclr_pkg::SEL_PORT_W-1:0]; // [R4]
   // Port 0 and values above the port count reach nothing
   assign port_ok = (port_num >= aclr_pkg::PORT_FIRST)
                    && (int'(port_num) <= NUM_PORTS); // [R16]
   assign port_idx = PORT_W'(port_num - aclr_pkg::PORT_FIRST); // [R11]

   // Host strobes
   assign wr_sel = i_reg_wr_en && (i_reg_addr == aclr_pkg::ADDR_SEL);
   assign wr_off = i_reg_wr_en && (i_reg_addr == aclr_pkg::ADDR_OFF);
   assign wr_data = i_reg_wr_en && (i_reg_addr == aclr_pkg::ADDR_DATA);
   // Data writes land only in write direction on a valid rule port
   assign data_hit = wr_data && sel_is_rules && !sel_is_read && port_ok; // [R15] [R18]
   assign busy = (state_ff != aclr_pkg::ST_IDLE);
   // Start while busy is dropped rather than queued
   assign start_req = data_hit && (off_ff == aclr_pkg::OFF_CTRL)
                      && i_reg_wdata[aclr_pkg::CTRL_START_BIT] && !busy; // [R9]

   // Byte fetched by a read trigger, offset taken from the write itself
   always_comb begin
      rd_loc = 8'h00;
      if (port_ok) begin
         if (i_reg_wdata <= aclr_pkg::OFF_LAST_CONTENT) begin
            rd_loc = stage_ff[port_idx][byte_lsb(i_reg_wdata) +: BB]
                     & loc_mask(i_reg_wdata); // [R6] [R20]
         end else if (i_reg_wdata == aclr_pkg::OFF_BE_HI) begin
            rd_loc = be_ff[port_idx][aclr_pkg::BE_BITS-1 -: BB]; // [R8]
         end else if (i_reg_wdata == aclr_pkg::OFF_BE_LO) begin
            rd_loc = be_ff[port_idx][BB-1:0]; // [R8]
         end else if (i_reg_wdata == aclr_pkg::OFF_CTRL) begin
            rd_loc = {done_ff, busy, 1'b0, ctrl_ff[port_idx]}; // [R9]
         end
      end
   end

   // Select and offset registers
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         sel_ff <= 8'h00;
         off_ff <= 8'h00;
      end else begin
         if (wr_sel) begin
            sel_ff <= i_reg_wdata;
         end
         if (wr_off) begin
            off_ff <= i_reg_wdata; // [R5]
         end
      end
   end

   // Data register: filled by a read trigger, or mirrors the byte written
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         data_ff <= 8'h00;
      end else if (wr_off && sel_is_rules && sel_is_read) begin
         data_ff <= rd_loc; // [R19] [R15]
      end else if (wr_data) begin
         data_ff <= i_reg_wdata; // [R15]
      end
   end

   // Per-port staging; host write follows the engine load so it wins a clash
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      always_ff @(posedge i_core_clk) begin
         if (i_sys_rst) begin
            stage_ff[p] <= aclr_pkg::ENTRY_RST; // [R10]
            be_ff[p] <= '0;
            ctrl_ff[p] <= aclr_pkg::CTRL_RST;
         end else begin
            // Only enabled bytes are refreshed from the table
            if (state_ff == aclr_pkg::ST_LOAD && eng_port_ff == PORT_W'(p)) begin
               stage_ff[p] <= (stage_ff[p] & ~bit_mask(be_ff[p][aclr_pkg::BE_BITS-1 -:
                              aclr_pkg::ENTRY_BYTES]))
                              | (tbl.rd_data & bit_mask(be_ff[p][aclr_pkg::BE_BITS-1 -:
                              aclr_pkg::ENTRY_BYTES])); // [R8]
            end
            if (data_hit && port_idx == PORT_W'(p)) begin
               if (off_ff <= aclr_pkg::OFF_LAST_CONTENT) begin
                  stage_ff[p][byte_lsb(off_ff) +: BB] <= i_reg_wdata & loc_mask(off_ff); // [R6] [R12] [R14]
               end else if (off_ff == aclr_pkg::OFF_BE_HI) begin
                  be_ff[p][aclr_pkg::BE_BITS-1 -: BB] <= i_reg_wdata; // [R8]
               end else if (off_ff == aclr_pkg::OFF_BE_LO) begin
                  // Byte enables of the reserved bytes 1 and 0 have no effect
                  be_ff[p][BB-1:0] <= i_reg_wdata; // [R8]
               end else if (off_ff == aclr_pkg::OFF_CTRL && !busy) begin
                  ctrl_ff[p] <= i_reg_wdata[aclr_pkg::CTRL_W-1:0]; // [R9]
               end
            end
         end
      end
   end

   // Engine next state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         aclr_pkg::ST_IDLE: begin
            if (start_req) begin
               nxt_state = i_reg_wdata[aclr_pkg::CTRL_DIR_BIT] ? aclr_pkg::ST_WRITE
                                                               : aclr_pkg::ST_WAIT; // [R9]
            end
         end
         aclr_pkg::ST_WRITE: nxt_state = aclr_pkg::ST_IDLE;
         aclr_pkg::ST_WAIT: nxt_state = aclr_pkg::ST_LOAD;
         aclr_pkg::ST_LOAD: nxt_state = aclr_pkg::ST_IDLE;
         default: nxt_state = aclr_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         state_ff <= aclr_pkg::ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Transfer target latched at start, so host may move on meanwhile
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         eng_port_ff <= '0;
         eng_entry_ff <= '0;
         eng_dir_wr_ff <= 1'b0;
      end else if (start_req) begin
         eng_port_ff <= port_idx; // [R11]
         eng_entry_ff <= i_reg_wdata[ENTRY_W-1:0]; // [R11]
         eng_dir_wr_ff <= i_reg_wdata[aclr_pkg::CTRL_DIR_BIT];
      end
   end

   // Done flag: cleared by a new start, set at the end of a transfer
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         done_ff <= 1'b0;
      end else if (state_ff == aclr_pkg::ST_WRITE || state_ff == aclr_pkg::ST_LOAD) begin
         done_ff <= 1'b1; // [R9]
      end else if (start_req) begin
         done_ff <= 1'b0;
      end
   end

   // Table requests from the engine; lookup port and entry passed straight through
   assign tbl.wr_en = (state_ff == aclr_pkg::ST_WRITE) && eng_dir_wr_ff;
   assign tbl.wr_port = eng_port_ff;
   assign tbl.wr_entry = eng_entry_ff;
   assign tbl.wr_data = stage_ff[eng_port_ff];
   assign tbl.wr_mask = be_ff[eng_port_ff][aclr_pkg::BE_BITS-1 -: aclr_pkg::ENTRY_BYTES]; // [R8]
   assign tbl.rd_port = eng_port_ff;
   assign tbl.rd_entry = eng_entry_ff;
   assign tbl.lk_port = i_lookup_port;
   assign tbl.lk_entry = i_lookup_entry;

   aclr_rule_table #(
      .NUM_PORTS(NUM_PORTS),
      .NUM_ENTRIES(NUM_ENTRIES)
   ) u_table (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .tbl(tbl.mem)
   );

   // Host read answer one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_reg_rdata <= 8'h00;
         o_reg_rd_valid <= 1'b0;
      end else begin
         o_reg_rd_valid <= i_reg_rd_en;
         case (i_reg_addr)
            aclr_pkg::ADDR_SEL: o_reg_rdata <= sel_ff;
            aclr_pkg::ADDR_OFF: o_reg_rdata <= off_ff;
            aclr_pkg::ADDR_DATA: o_reg_rdata <= data_ff; // [R15]
            default: o_reg_rdata <= 8'h00;
         endcase
      end
   end

   // Lookup result, two cycles after the request
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_lookup_word <= aclr_pkg::ENTRY_RST;
         o_lookup_first_index <= '0;
         o_lookup_mode <= aclr_pkg::MODE_OFF;
         o_lookup_active <= 1'b0;
      end else begin
         o_lookup_word <= tbl.lk_data;
         o_lookup_first_index <= tbl.lk_data[byte_lsb(aclr_pkg::OFF_FIRST) +:
                                 aclr_pkg::FIRST_W]; // [R13]
         o_lookup_mode <= tbl.lk_data[byte_lsb(aclr_pkg::OFF_MODE) + aclr_pkg::MODE_LSB +:
                          aclr_pkg::MODE_W]; // [R14]
         o_lookup_active <= tbl.lk_data[byte_lsb(aclr_pkg::OFF_MODE) + aclr_pkg::MODE_LSB +:
                            aclr_pkg::MODE_W] != aclr_pkg::MODE_OFF; // [R14]
      end
   end

endmodule : aclr_indirect_access
`default_nettype wire

// ---- rtl/aclr_pkg.sv ----
// Shared constants and types for the rule-table indirect access block
package aclr_pkg;

   // Table geometry
   localparam int NUM_PORTS = 5;
   localparam int NUM_ENTRIES = 16;
   localparam int ENTRY_BITS = 112;
   localparam int ENTRY_BYTES = 14;
   localparam int BYTE_BITS = 8;
   localparam int BE_BITS = 16;
   localparam logic [ENTRY_BITS-1:0] ENTRY_RST = '0;

   // Direct register addresses seen by the host
   localparam logic [7:0] ADDR_SEL = 8'h6E;
   localparam logic [7:0] ADDR_OFF = 8'h6F;
   localparam logic [7:0] ADDR_DATA = 8'hA0;

   // Fields of the select register
   localparam int SEL_TGT_LSB = 5;
   localparam int SEL_TGT_W = 3;
   localparam int SEL_DIR_BIT = 4;
   localparam int SEL_PORT_W = 4;
   localparam logic [SEL_TGT_W-1:0] TARGET_RULES = 3'h2;
   localparam logic [SEL_PORT_W-1:0] PORT_FIRST = 4'h1;

   // Offsets inside one port rule space
   localparam logic [7:0] OFF_FIRST = 8'h00;
   localparam logic [7:0] OFF_MODE = 8'h01;
   localparam logic [7:0] OFF_LAST_CONTENT = 8'h0D;
   localparam logic [7:0] OFF_BE_HI = 8'h10;
   localparam logic [7:0] OFF_BE_LO = 8'h11;
   localparam logic [7:0] OFF_CTRL = 8'h12;

   // Writable-bit masks of each location
   localparam logic [7:0] MASK_FIRST = 8'h0F;
   localparam logic [7:0] MASK_MODE = 8'h3F;
   localparam logic [7:0] MASK_FULL = 8'hFF;
   localparam logic [7:0] MASK_NONE = 8'h00;

   // Transfer control and status byte
   localparam int CTRL_W = 5;
   localparam int CTRL_ENTRY_W = 4;
   localparam int CTRL_DIR_BIT = 4;
   localparam int CTRL_START_BIT = 5;
   localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

   // Rule header fields
   localparam int FIRST_W = 4;
   localparam int MODE_LSB = 4;
   localparam int MODE_W = 2;

   typedef enum logic [1:0] {
      MODE_OFF = 2'h0,
      MODE_MAC = 2'h1,
      MODE_IP = 2'h2,
      MODE_L4 = 2'h3
   } aclr_mode_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_WRITE = 4'h2,
      ST_WAIT = 4'h4,
      ST_LOAD = 4'h8
   } aclr_state_t;

endpackage : aclr_pkg

// ---- rtl/aclr_rule_table.sv ----
// Rule table storage: all ports, all entries, byte-masked writes
`timescale 1ns/1ps
`default_nettype none
module aclr_rule_table #(
   parameter int NUM_PORTS = aclr_pkg::NUM_PORTS,
   parameter int NUM_ENTRIES = aclr_pkg::NUM_ENTRIES
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   // Engine side
   aclr_tbl_if.mem tbl
);
   localparam int DEPTH = NUM_PORTS * NUM_ENTRIES;
   localparam int ENTRY_W = $clog2(NUM_ENTRIES);

   logic [aclr_pkg::ENTRY_BITS-1:0] mem_ff [DEPTH];
   logic [aclr_pkg::ENTRY_BITS-1:0] rd_ff;
   logic [aclr_pkg::ENTRY_BITS-1:0] lk_ff;

   // Flat row number from port index and entry
   function automatic int row(input logic [$clog2(NUM_PORTS)-1:0] port,
                              input logic [ENTRY_W-1:0] entry);
      return int'(port) * NUM_ENTRIES + int'(entry);
   endfunction : row

   // Byte-masked write; reset clears every rule so all modes start disabled
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_ff[i] <= aclr_pkg::ENTRY_RST;
         end
      end else if (tbl.wr_en) begin
         for (int b = 0; b < aclr_pkg::ENTRY_BYTES; b++) begin
            if (tbl.wr_mask[b]) begin
               mem_ff[row(tbl.wr_port, tbl.wr_entry)][b*aclr_pkg::BYTE_BITS +: aclr_pkg::BYTE_BITS]
                  <= tbl.wr_data[b*aclr_pkg::BYTE_BITS +: aclr_pkg::BYTE_BITS];
            end
         end
      end
   end

   // Two registered read ports: transfer engine and rule lookup
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         rd_ff <= aclr_pkg::ENTRY_RST;
         lk_ff <= aclr_pkg::ENTRY_RST;
      end else begin
         rd_ff <= mem_ff[row(tbl.rd_port, tbl.rd_entry)];
         lk_ff <= mem_ff[row(tbl.lk_port, tbl.lk_entry)];
      end
   end

   assign tbl.rd_data = rd_ff;
   assign tbl.lk_data = lk_ff;

endmodule : aclr_rule_table
`default_nettype wire

// ---- rtl/aclr_tbl_if.sv ----
// Connection between the access engine and the rule table storage
`timescale 1ns/1ps
`default_nettype none
interface aclr_tbl_if #(
   parameter int PORT_W = 3,
   parameter int ENTRY_W = 4,
   parameter int DATA_W = 112,
   parameter int MASK_W = 14
);
   logic wr_en;
   logic [PORT_W-1:0] wr_port;
   logic [ENTRY_W-1:0] wr_entry;
   logic [DATA_W-1:0] wr_data;
   logic [MASK_W-1:0] wr_mask;
   logic [PORT_W-1:0] rd_port;
   logic [ENTRY_W-1:0] rd_entry;
   logic [DATA_W-1:0] rd_data;
   logic [PORT_W-1:0] lk_port;
   logic [ENTRY_W-1:0] lk_entry;
   logic [DATA_W-1:0] lk_data;

   modport eng (
      output wr_en, wr_port, wr_entry, wr_data, wr_mask, rd_port, rd_entry, lk_port, lk_entry,
      input rd_data, lk_data
   );
   modport mem (
      input wr_en, wr_port, wr_entry, wr_data, wr_mask, rd_port, rd_entry, lk_port, lk_entry,
      output rd_data, lk_data
   );
endinterface : aclr_tbl_if
`default_nettype wire

// ---- verif/acl_rule_indirect_access_bench.sv ----
// Self-checking bench for the rule-table indirect access block
`timescale 1ns/1ps
`default_nettype none
module acl_rule_indirect_access_bench;
   typedef struct packed {
      logic [3:0] port;
      logic [7:0] off;
      logic [7:0] din;
      logic [7:0] dout;
   } aclr_row_t;
   logic clk, rst, wr_en, rd_en, rd_valid, active, ok;
   logic [7:0] addr, wdata, rdata, got;
   logic [2:0] lk_port;
   logic [3:0] lk_entry, first_idx;
   logic [1:0] mode;
   logic [111:0] word, exp_word;
   int failures, n_tests;
   // Port, offset, written byte, byte read back
   aclr_row_t rows [13] = '{
      '{4'h1, 8'h00, 8'hFF, 8'h0F},
      '{4'h2, 8'h01, 8'hC5, 8'h05},
      '{4'h2, 8'h01, 8'hD5, 8'h15},
      '{4'h2, 8'h01, 8'hE5, 8'h25},
      '{4'h2, 8'h01, 8'hF5, 8'h35},
      '{4'h3, 8'h05, 8'hA5, 8'hA5},
      '{4'h4, 8'h0E, 8'hFF, 8'h00},
      '{4'h5, 8'h0F, 8'h55, 8'h00},
      '{4'h1, 8'h10, 8'hFC, 8'hFC},
      '{4'h1, 8'h11, 8'hC3, 8'hC3},
      '{4'h2, 8'h13, 8'hFF, 8'h00},
      '{4'h5, 8'h0C, 8'h81, 8'h81},
      '{4'h5, 8'h0D, 8'h3C, 8'h3C}
   };

   aclr_indirect_access dut (.i_core_clk(clk), .i_sys_rst(rst), .i_reg_wr_en(wr_en),
      .i_reg_rd_en(rd_en), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
      .o_reg_rd_valid(rd_valid), .i_lookup_port(lk_port), .i_lookup_entry(lk_entry),
      .o_lookup_word(word), .o_lookup_first_index(first_idx), .o_lookup_mode(mode),
      .o_lookup_active(active));
   aclr_host_model host (.i_core_clk(clk), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr),
      .o_wdata(wdata), .i_rdata(rdata), .i_rd_valid(rd_valid));

   // 200 MHz clock
   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end

   // Entry byte pattern and the writable bits of each offset
   function automatic logic [7:0] val(input int k);
      val = 8'h5A + 8'h13 * k[7:0];
   endfunction : val
   function automatic logic [7:0] msk(input int k);
      msk = (k == 0) ? 8'h0F : (k == 1) ? 8'h3F : 8'hFF;
   endfunction : msk

   task automatic give_verdict();
      if (failures == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict

   task automatic check(input string what, input logic [111:0] e, input logic [111:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask : check

   // Valid flag checked with the byte
   task automatic rd_check(input string what, input logic [3:0] p, input logic [7:0] off,
      input logic [7:0] e);
      host.rd_byte(p, off, got, ok);
      check(what, {1'h1, e}, {ok, got});
   endtask : rd_check

   // Poll port 2 status; a stuck engine ends the run
   task automatic wait_done(input logic [7:0] e);
      for (int i = 0; i < 20; i++) begin
         host.rd_byte(4'h2, aclr_pkg::OFF_CTRL, got, ok);
         if (got[7] === 1'h1) break;
      end
      check("status", {1'h1, e}, {ok, got});
      if (got[7] !== 1'h1) give_verdict();
   endtask : wait_done

   // Hang guard
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      give_verdict();
   end

   initial begin
      rst = 1'h1;
      lk_port = 3'h0;
      lk_entry = 4'h0;
      failures = 0;
      n_tests = 0;
      repeat (16) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      #1;
      check("reset word", 112'h0, word);
      check("reset active", 1'h0, active);
      rd_check("reset first index", 4'h1, 8'h00, 8'h00);
      rd_check("reset enables", 4'h3, aclr_pkg::OFF_BE_HI, 8'h00);
      foreach (rows[i]) begin
         host.wr_byte(rows[i].port, rows[i].off, rows[i].din);
         rd_check("row byte", rows[i].port, rows[i].off, rows[i].dout);
      end
      rd_check("other port", 4'h4, 8'h05, 8'h00);
      // Whole entry staged, then committed to entry 7 of port 2
      for (int k = 0; k < 14; k++) begin
         host.wr_byte(4'h2, k[7:0], val(k));
         exp_word[8*(13-k)+:8] = val(k) & msk(k);
      end
      host.wr_byte(4'h2, aclr_pkg::OFF_BE_HI, 8'hFF);
      host.wr_byte(4'h2, aclr_pkg::OFF_BE_LO, 8'hFC);
      host.wr_byte(4'h2, aclr_pkg::OFF_CTRL, 8'h37);
      wait_done(8'h97);
      @(posedge clk);
      lk_port <= 3'h1;
      lk_entry <= 4'h7;
      repeat (3) @(posedge clk);
      #1;
      check("lookup word", exp_word, word);
      check("first index", 4'hA, first_idx);
      check("mode", 2'h2, mode);
      check("active", 1'h1, active);
      // Load back over cleared offsets 5 and 6 with only byte 10 enabled
      host.wr_byte(4'h2, 8'h05, 8'h00);
      host.wr_byte(4'h2, 8'h06, 8'h00);
      host.wr_byte(4'h2, aclr_pkg::OFF_BE_HI, 8'h04);
      host.wr_byte(4'h2, aclr_pkg::OFF_BE_LO, 8'h00);
      host.wr_byte(4'h2, aclr_pkg::OFF_CTRL, 8'h27);
      wait_done(8'h87);
      rd_check("enabled byte", 4'h2, 8'h05, val(5));
      rd_check("disabled byte", 4'h2, 8'h06, 8'h00);
      // Data writes off target or under read select spare the stage
      host.wr(aclr_pkg::ADDR_SEL, 8'h82);
      host.wr(aclr_pkg::ADDR_OFF, 8'h05);
      host.wr(aclr_pkg::ADDR_DATA, 8'hEE);
      host.rd(aclr_pkg::ADDR_DATA, got, ok);
      check("data mirror", {1'h1, 8'hEE}, {ok, got});
      host.wr(aclr_pkg::ADDR_SEL, 8'h52);
      host.wr(aclr_pkg::ADDR_OFF, 8'h05);
      host.wr(aclr_pkg::ADDR_DATA, 8'hEE);
      rd_check("guarded byte", 4'h2, 8'h05, val(5));
      host.rd(8'h6D, got, ok);
      check("unmapped", {1'h1, 8'h00}, {ok, got});
      give_verdict();
   end
endmodule : acl_rule_indirect_access_bench
`default_nettype wire

// ---- verif/aclr_host_model.sv ----
// Host model for the byte register port of the rule-table block
`timescale 1ns/1ps
`default_nettype none
module aclr_host_model (
   // Clock
   input wire logic i_core_clk,
   // Register port towards the device
   output logic o_wr_en,
   output logic o_rd_en,
   output logic [7:0] o_addr,
   output logic [7:0] o_wdata,
   input wire logic [7:0] i_rdata,
   input wire logic i_rd_valid
);
   // Idle bus from time zero
   initial begin
      o_wr_en = 1'h0;
      o_rd_en = 1'h0;
      o_addr = 8'h00;
      o_wdata = 8'h00;
   end

   // One write; address and data garbled after release
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_core_clk);
      o_wr_en <= 1'h1;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_core_clk);
      o_wr_en <= 1'h0;
      o_addr <= ~a;
      o_wdata <= ~d;
   endtask : wr

   // One read; the answer is sampled 1 ns after the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(posedge i_core_clk);
      o_rd_en <= 1'h1;
      o_addr <= a;
      @(posedge i_core_clk);
      o_rd_en <= 1'h0;
      o_addr <= ~a;
      #1;
      ok = i_rd_valid;
      d = i_rdata;
   endtask : rd

   // Staging byte write of port p (1 to 5)
   task automatic wr_byte(input logic [3:0] p, input logic [7:0] off, input logic [7:0] d);
      logic [7:0] r;
      logic ok;
      rd(aclr_pkg::ADDR_SEL, r, ok);
      wr(aclr_pkg::ADDR_SEL, {aclr_pkg::TARGET_RULES, 1'h0, p});
      wr(aclr_pkg::ADDR_OFF, off);
      wr(aclr_pkg::ADDR_DATA, d);
   endtask : wr_byte

   // Staging byte read; control bytes written and read back first
   task automatic rd_byte(input logic [3:0] p, input logic [7:0] off, output logic [7:0] d,
      output logic ok);
      logic [7:0] r;
      logic k1, k2;
      wr(aclr_pkg::ADDR_SEL, {aclr_pkg::TARGET_RULES, 1'h1, p});
      rd(aclr_pkg::ADDR_SEL, r, k1);
      wr(aclr_pkg::ADDR_OFF, off);
      rd(aclr_pkg::ADDR_OFF, r, k2);
      rd(aclr_pkg::ADDR_DATA, d, ok);
      ok = ok & k1 & k2;
   endtask : rd_byte
endmodule : aclr_host_model
`default_nettype wire

// ---- verif/aclr_indirect_access_properties.sv ----
// Port-level checks of the rule-table indirect access block
`timescale 1ns/1ps
`default_nettype none
module aclr_indirect_access_properties (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   // Host register port
   input wire logic i_reg_wr_en,
   input wire logic i_reg_rd_en,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] o_reg_rdata,
   input wire logic o_reg_rd_valid,
   // Lookup results
   input wire logic [aclr_pkg::ENTRY_BITS-1:0] o_lookup_word,
   input wire logic [aclr_pkg::FIRST_W-1:0] o_lookup_first_index,
   input wire logic [aclr_pkg::MODE_W-1:0] o_lookup_mode,
   input wire logic o_lookup_active
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_sys_rst);

   // Only three direct addresses exist
   logic mapped;
   assign mapped = i_reg_addr inside {aclr_pkg::ADDR_SEL, aclr_pkg::ADDR_OFF, aclr_pkg::ADDR_DATA};

   a_read_answer_timing: assert property (i_reg_rd_en |=> o_reg_rd_valid)
      else $error("read answer missing");
   a_valid_needs_read: assert property (o_reg_rd_valid |-> $past(i_reg_rd_en))
      else $error("read answer without request");
   a_unmapped_read_zero: assert property (i_reg_rd_en && !mapped |=> o_reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   // Stored byte read back two cycles after its write
   property p_readback(logic [7:0] a);
      (i_reg_wr_en && i_reg_addr == a) ##1 !i_reg_wr_en ##1 (i_reg_rd_en && i_reg_addr == a)
         |=> o_reg_rdata == $past(i_reg_wdata, 3);
   endproperty : p_readback
   a_select_readback: assert property (p_readback(aclr_pkg::ADDR_SEL))
      else $error("select byte lost");
   a_offset_readback: assert property (p_readback(aclr_pkg::ADDR_OFF))
      else $error("offset byte lost");
   a_data_readback: assert property (p_readback(aclr_pkg::ADDR_DATA))
      else $error("data byte lost");
   a_first_index_field: assert property (o_lookup_first_index == o_lookup_word[107:104])
      else $error("first index wrong");
   a_mode_and_active: assert property (o_lookup_mode == o_lookup_word[101:100]
      && o_lookup_active == (o_lookup_mode != 2'h0)) else $error("mode field wrong");
   a_reserved_bits_zero: assert property (o_lookup_word[111:108] == 4'h0
      && o_lookup_word[103:102] == 2'h0) else $error("reserved entry bits set");

   // Main scenarios reached
   c_read_done: cover property (o_reg_rd_valid && o_reg_rdata[7]);
   c_rule_active: cover property (o_lookup_active);
   c_unmapped_read: cover property (i_reg_rd_en && !mapped);
endmodule : aclr_indirect_access_properties

bind aclr_indirect_access aclr_indirect_access_properties u_props (.i_core_clk(i_core_clk),
   .i_sys_rst(i_sys_rst), .i_reg_wr_en(i_reg_wr_en), .i_reg_rd_en(i_reg_rd_en),
   .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
   .o_reg_rd_valid(o_reg_rd_valid), .o_lookup_word(o_lookup_word),
   .o_lookup_first_index(o_lookup_first_index), .o_lookup_mode(o_lookup_mode),
   .o_lookup_active(o_lookup_active));
`default_nettype wire
